/* File: hdl/paged_mac_register_decoder.sv */
// Purpose: paged register bank and address decoder of the MAC core
// Assumes: single 10 MHz clock, synchronous active-high reset,
//          host strobes rd/wr are one-cycle pulses synchronous to clock
// Notes: read data registered one cycle after the strobe
`timescale 1ns/1ps
module paged_mac_register_decoder
  import mac_regs_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire host_req_t hostReq,
  input wire core_stat_t coreStat,
  output logic [15:0] readData,
  output logic readValid,
  output logic [7:0] commandOut,
  output logic wordWidth,
  output logic [47:0] stationAddress,
  output logic [63:0] multicastHash,
  output logic [7:0] rxWritePage,
  output logic softResetPulse,
  output logic hostWakePulse,
  output logic dataPortWr,
  output logic dataPortRd
);

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] rxFirst;
    logic [7:0] rxEnd;
    logic [7:0] boundary;
    logic [7:0] txPageStart;
    logic [15:0] txLength;
    logic [7:0] irqStatus;
    logic [15:0] xferStart;
    logic [15:0] xferCount;
    logic [7:0] rxCfg;
    logic [7:0] txCfg;
    logic [7:0] dataCfg;
    logic [7:0] irqMask;
    logic [47:0] station;
    logic [63:0] mcast;
    logic [7:0] curPage;
    logic [7:0] gap1;
    logic [7:0] gap2;
    logic [7:0] mgmt;
    logic [7:0] bufCfg;
    logic [7:0] frameGap;
    logic [7:0] jamLimit;
    logic [11:0] maxFrame;
    logic [7:0] flowCtl;
    logic [7:0] macCfg;
    logic [15:0] vlan;
    logic [7:0] byteOrder;
    logic [15:0] rdata;
    logic rvalid;
    logic swReset;
    logic wake;
    logic dataWr;
    logic dataRd;
  } state_t;

  state_t state_reg;
  state_t state_next;
  page_t page;
  logic [3:0] lo;
  logic [7:0] wb;
  logic inBank;

  assign page = page_t'(state_reg.command[PAGE_HI:PAGE_LO]);
  assign lo = hostReq.addr[3:0];
  assign wb = hostReq.wdata[7:0];
  // banked window is 01h..0Fh; 00h and 10h up skip the page
  assign inBank = (hostReq.addr >= OFF_PAGED_LO) &&
    (hostReq.addr <= OFF_PAGED_HI);

  // next-state: write decode then read mux
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.swReset = 1'b0;
    state_next.wake = 1'b0;
    state_next.dataWr = 1'b0;
    state_next.dataRd = 1'b0;
    if (hostReq.wr) begin
      if (hostReq.addr == OFF_CMD) begin
        state_next.command = wb;
      end else if (inBank) begin
        case (page)
          PAGE0: begin
            case (lo)
              P0_FIRST: state_next.rxFirst = wb;
              P0_STOP: state_next.rxEnd = wb;
              P0_BNDRY: state_next.boundary = wb;
              P0_TXST: state_next.txPageStart = wb;
              P0_COLL: state_next.txLength[7:0] = wb;
              P0_CURPG: state_next.txLength[15:8] = wb;
              P0_IRQ: state_next.irqStatus = wb;
              P0_XADL: state_next.xferStart[7:0] = wb;
              P0_XADH: state_next.xferStart[15:8] = wb;
              P0_XCNL: state_next.xferCount[7:0] = wb;
              P0_XCNH: state_next.xferCount[15:8] = wb;
              P0_RXC: state_next.rxCfg = wb;
              P0_TXC: state_next.txCfg = wb;
              P0_DCF: state_next.dataCfg = wb;
              P0_MSK: state_next.irqMask = wb;
              default: state_next.command = state_reg.command;
            endcase
          end
          PAGE1: begin
            if (lo == P1_CURPG) begin
              state_next.curPage = wb;
            end else if (lo < P1_CURPG) begin
              // station bytes 0..5 at 01h..06h
              state_next.station[(lo - 4'd1) * 8 +: 8] = wb;
            end else begin
              state_next.mcast[(lo - P1_MCAST0) * 8 +: 8] = wb;
            end
          end
          default: state_next.command = state_reg.command; // pages 2/3 open
        endcase
      end else begin
        case (hostReq.addr)
          OFF_DATA_LO: state_next.dataWr = 1'b1;
          OFF_DATA_HI: state_next.dataWr = 1'b1;
          OFF_GAP1: state_next.gap1 = wb;
          OFF_GAP2: state_next.gap2 = wb;
          OFF_MGMT: state_next.mgmt = wb;
          OFF_BUFCFG: state_next.bufCfg = wb;
          OFF_FGAP: state_next.frameGap = wb;
          OFF_DEVSTAT: state_next.jamLimit = wb;
          OFF_MAXLO: state_next.maxFrame[7:0] = wb;
          OFF_MAXHI: state_next.maxFrame[11:8] = wb[3:0];
          OFF_FLOW: state_next.flowCtl = wb;
          OFF_MACCFG: state_next.macCfg = wb;
          OFF_VLANLO: state_next.vlan[7:0] = wb;
          OFF_VLANHI: state_next.vlan[15:8] = wb;
          OFF_BYTEORD: state_next.byteOrder = wb;
          OFF_RSTWAKE: state_next.wake = 1'b1;
          default: state_next.wake = 1'b0;
        endcase
      end
    end
    // read mux; reserved and pages 2/3 read as zero
    if (hostReq.rd) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = {8'h00, RSVD_READ};
      if (hostReq.addr == OFF_CMD) begin
        state_next.rdata[7:0] = state_reg.command;
      end else if (inBank) begin
        case (page)
          PAGE0: begin
            case (lo)
              P0_FIRST: state_next.rdata[7:0] = state_reg.rxFirst;
              P0_STOP: state_next.rdata[7:0] = state_reg.rxEnd;
              P0_BNDRY: state_next.rdata[7:0] = state_reg.boundary;
              P0_TXST: state_next.rdata[7:0] = coreStat.txStatus;
              P0_COLL: state_next.rdata[7:0] = coreStat.collCount;
              P0_CURPG: state_next.rdata[7:0] = state_reg.curPage;
              P0_IRQ: state_next.rdata[7:0] = state_reg.irqStatus;
              P0_XADL: state_next.rdata[7:0] = coreStat.xferAddrNow[7:0];
              P0_XADH: state_next.rdata[7:0] = coreStat.xferAddrNow[15:8];
              P0_RXC: state_next.rdata[7:0] = coreStat.rxStatus;
              P0_TXC: state_next.rdata[7:0] = coreStat.alignTally;
              P0_DCF: state_next.rdata[7:0] = coreStat.crcTally;
              P0_MSK: state_next.rdata[7:0] = coreStat.lostTally;
              default: state_next.rdata[7:0] = RSVD_READ;
            endcase
          end
          PAGE1: begin
            if (lo == P1_CURPG) begin
              state_next.rdata[7:0] = state_reg.curPage;
            end else if (lo < P1_CURPG) begin
              state_next.rdata[7:0] =
                state_reg.station[(lo - 4'd1) * 8 +: 8];
            end else begin
              state_next.rdata[7:0] =
                state_reg.mcast[(lo - P1_MCAST0) * 8 +: 8];
            end
          end
          default: state_next.rdata[7:0] = RSVD_READ;
        endcase
      end else begin
        case (hostReq.addr)
          OFF_DATA_LO, OFF_DATA_HI: state_next.dataRd = 1'b1;
          OFF_GAP1: state_next.rdata[7:0] = state_reg.gap1;
          OFF_GAP2: state_next.rdata[7:0] = state_reg.gap2;
          OFF_MGMT: state_next.rdata[7:0] = state_reg.mgmt;
          OFF_BUFCFG: state_next.rdata[7:0] = state_reg.bufCfg;
          OFF_FGAP: state_next.rdata[7:0] = state_reg.frameGap;
          OFF_DEVSTAT: state_next.rdata[7:0] = coreStat.devStatus;
          OFF_MAXLO: state_next.rdata[7:0] = state_reg.maxFrame[7:0];
          OFF_MAXHI: state_next.rdata[7:0] =
            {4'h0, state_reg.maxFrame[11:8]};
          OFF_FLOW: state_next.rdata[7:0] = state_reg.flowCtl;
          OFF_MACCFG: state_next.rdata[7:0] = state_reg.macCfg;
          OFF_VLANLO: state_next.rdata[7:0] = coreStat.txEndPage;
          OFF_RSTWAKE: state_next.swReset = 1'b1;
          default: state_next.rdata[7:0] = RSVD_READ;
        endcase
      end
    end
  end

  // single register stage; reset values per register
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.command <= CMD_RST;
      state_reg.boundary <= BNDRY_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readData = state_reg.rdata;
  assign readValid = state_reg.rvalid;
  assign commandOut = state_reg.command;
  assign wordWidth = state_reg.dataCfg[WIDTH_BIT];
  assign stationAddress = state_reg.station;
  assign multicastHash = state_reg.mcast;
  assign rxWritePage = state_reg.curPage;
  assign softResetPulse = state_reg.swReset;
  assign hostWakePulse = state_reg.wake;
  assign dataPortWr = state_reg.dataWr;
  assign dataPortRd = state_reg.dataRd;

  // read side: every answer is one byte wide, upper lane zero, valid pulse
  read_byte_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd |=> readValid && readData[15:8] == 8'h00)
    else $error("read not valid or upper byte set");
  // command register is reachable on every page and holds between writes
  page_sel_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.wr && hostReq.addr == OFF_CMD |=>
      commandOut[PAGE_HI:PAGE_LO] == $past(hostReq.wdata[PAGE_HI:PAGE_LO]))
    else $error("page select not loaded");
  cmd_hold_a: assert property (@(posedge clock) disable iff (srst)
    !(hostReq.wr && hostReq.addr == OFF_CMD) |=> $stable(commandOut))
    else $error("command changed without a write");
  // page 0: status on the read side, written registers hidden except at 01h..03h and 07h
  bank_p0_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == {1'b0, P0_TXST} && page == PAGE0 |=>
      readValid && readData[7:0] == $past(coreStat.txStatus))
    else $error("tx status read wrong");
  coll_read_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == {1'b0, P0_COLL} && page == PAGE0 |=>
      readData[7:0] == $past(coreStat.collCount))
    else $error("collision count read wrong");
  xfer_addr_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == {1'b0, P0_XADH} && page == PAGE0 |=>
      readData[7:0] == $past(coreStat.xferAddrNow[15:8]))
    else $error("transfer address high read wrong");
  p0_reserved_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && page == PAGE0 && (hostReq.addr == {1'b0, P0_XCNL} ||
      hostReq.addr == {1'b0, P0_XCNH}) |=> readData == 16'h0000)
    else $error("byte count offset read not reserved");
  lost_tally_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == {1'b0, P0_MSK} && page == PAGE0 |=>
      readData[7:0] == $past(coreStat.lostTally))
    else $error("lost frame tally read wrong");
  word_width_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.wr && hostReq.addr == {1'b0, P0_DCF} && page == PAGE0 |=>
      wordWidth == $past(hostReq.wdata[WIDTH_BIT]))
    else $error("word width not loaded");
  // page 1: station bytes, filter bytes and the writable current page; page 2 reads zero
  bank_p1_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.wr && hostReq.addr == {1'b0, P1_CURPG} && page == PAGE1 |=>
      rxWritePage == $past(hostReq.wdata[7:0]))
    else $error("page 1 current page write lost");
  station_byte_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.wr && hostReq.addr == OFF_PAGED_LO && page == PAGE1 |=>
      stationAddress[7:0] == $past(hostReq.wdata[7:0]))
    else $error("station byte 0 lost");
  mcast_byte_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.wr && hostReq.addr == {1'b0, P1_MCAST0} && page == PAGE1 |=>
      multicastHash[7:0] == $past(hostReq.wdata[7:0]))
    else $error("filter byte 0 lost");
  page2_read_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && inBank && page == PAGE2 |=> readData == 16'h0000)
    else $error("page 2 read not zero");
  // upper block decodes the same whatever page is selected
  dev_status_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == OFF_DEVSTAT |=>
      readData[7:0] == $past(coreStat.devStatus))
    else $error("device status read wrong");
  tx_end_page_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == OFF_VLANLO |=>
      readData[7:0] == $past(coreStat.txEndPage))
    else $error("tx end page read wrong");
  rsvd_read_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == OFF_VLANHI |=> readData == 16'h0000)
    else $error("reserved read not zero");
  byte_order_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == OFF_BYTEORD |=> readData == 16'h0000)
    else $error("byte order read not reserved");
  max_frame_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.wr && hostReq.addr == OFF_MAXHI ##1 !hostReq.wr ##1
      hostReq.rd && hostReq.addr == OFF_MAXHI |=>
      readData[7:0] == {4'h0, $past(hostReq.wdata[3:0], 3)})
    else $error("max frame high mismatch");
  data_port_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && (hostReq.addr == OFF_DATA_LO ||
      hostReq.addr == OFF_DATA_HI) |=> dataPortRd && readData == 16'h0000)
    else $error("data port read pulse wrong");
  // strobes on the reset/wake offset give exactly one-cycle pulses
  soft_rst_a: assert property (@(posedge clock) disable iff (srst)
    hostReq.rd && hostReq.addr == OFF_RSTWAKE |=> softResetPulse ##1
      (!softResetPulse || $past(hostReq.rd && hostReq.addr == OFF_RSTWAKE)))
    else $error("soft reset pulse wrong");
  wake_pulse_a: assert property (@(posedge clock) disable iff (srst)
    hostWakePulse |-> $past(hostReq.wr) &&
      $past(hostReq.addr) == OFF_RSTWAKE)
    else $error("wake without write");
  // main scenarios: banked pages, data port and the two pulses
  cov_p1_c: cover property (@(posedge clock)
    hostReq.wr && page == PAGE1 && inBank);
  cov_p2_c: cover property (@(posedge clock)
    hostReq.rd && page == PAGE2 && inBank);
  cov_data_c: cover property (@(posedge clock) dataPortRd);
  cov_sr_c: cover property (@(posedge clock) softResetPulse);
  cov_wake_c: cover property (@(posedge clock) hostWakePulse);
endmodule

/* File: shared/mac_regs_pkg.sv */
// Purpose: shared constants and types for the paged MAC register decoder
// Assumes: 8-bit core registers, 16-bit data port, offsets 00h..1Fh
// Notes: offsets are byte offsets on the host bus
package mac_regs_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_PAGED_LO = 5'h01;
  localparam logic [4:0] OFF_PAGED_HI = 5'h0F;
  localparam logic [4:0] OFF_DATA_LO = 5'h10;
  localparam logic [4:0] OFF_DATA_HI = 5'h11;
  localparam logic [4:0] OFF_GAP1 = 5'h12;
  localparam logic [4:0] OFF_GAP2 = 5'h13;
  localparam logic [4:0] OFF_MGMT = 5'h14;
  localparam logic [4:0] OFF_BUFCFG = 5'h15;
  localparam logic [4:0] OFF_FGAP = 5'h16;
  localparam logic [4:0] OFF_DEVSTAT = 5'h17;
  localparam logic [4:0] OFF_MAXLO = 5'h18;
  localparam logic [4:0] OFF_MAXHI = 5'h19;
  localparam logic [4:0] OFF_FLOW = 5'h1A;
  localparam logic [4:0] OFF_MACCFG = 5'h1B;
  localparam logic [4:0] OFF_VLANLO = 5'h1C;
  localparam logic [4:0] OFF_VLANHI = 5'h1D;
  localparam logic [4:0] OFF_BYTEORD = 5'h1E;
  localparam logic [4:0] OFF_RSTWAKE = 5'h1F;
  // page 0 / page 1 offsets inside the banked window
  localparam logic [3:0] P0_FIRST = 4'h1;
  localparam logic [3:0] P0_STOP = 4'h2;
  localparam logic [3:0] P0_BNDRY = 4'h3;
  localparam logic [3:0] P0_TXST = 4'h4;
  localparam logic [3:0] P0_COLL = 4'h5;
  localparam logic [3:0] P0_CURPG = 4'h6;
  localparam logic [3:0] P0_IRQ = 4'h7;
  localparam logic [3:0] P0_XADL = 4'h8;
  localparam logic [3:0] P0_XADH = 4'h9;
  localparam logic [3:0] P0_XCNL = 4'hA;
  localparam logic [3:0] P0_XCNH = 4'hB;
  localparam logic [3:0] P0_RXC = 4'hC;
  localparam logic [3:0] P0_TXC = 4'hD;
  localparam logic [3:0] P0_DCF = 4'hE;
  localparam logic [3:0] P0_MSK = 4'hF;
  localparam logic [3:0] P1_CURPG = 4'h7;
  localparam logic [3:0] P1_MCAST0 = 4'h8;
  // field positions
  localparam int PAGE_HI = 7;
  localparam int PAGE_LO = 6;
  localparam int WIDTH_BIT = 0;
  // reset values and the zero / reserved read constants
  localparam logic [7:0] CMD_RST = 8'h21;
  localparam logic [7:0] BNDRY_RST = 8'h4C;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'h00;
  typedef enum logic [1:0] {
    PAGE0 = 2'b00,
    PAGE1 = 2'b01,
    PAGE2 = 2'b10,
    PAGE3 = 2'b11
  } page_t;
  // host bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } host_req_t;
  // status inputs sampled from the MAC core
  typedef struct packed {
    logic [7:0] txStatus;
    logic [7:0] collCount;
    logic [7:0] rxStatus;
    logic [7:0] alignTally;
    logic [7:0] crcTally;
    logic [7:0] lostTally;
    logic [15:0] xferAddrNow;
    logic [7:0] txEndPage;
    logic [7:0] devStatus;
  } core_stat_t;
endpackage

/* File: sim/host_model.sv */
// Purpose: host processor model driving the register bus
// Assumes: strobes are one-cycle pulses launched at a rising edge
// Notes: idle address and data show inverted last values
`timescale 1ns/1ps
module host_model
  import mac_regs_pkg::*;
(
  input wire logic clock,
  output host_req_t hostReq,
  input wire logic [15:0] readData,
  input wire logic readValid
);
  // bus starts idle with no strobe
  initial hostReq = '0;
  // one strobe cycle, then idle with inverted fields so stale values hurt
  task automatic busCycle(input logic r, input logic [4:0] a,
                          input logic [15:0] d);
    @(posedge clock);
    hostReq <= '{rd: r, wr: ~r, addr: a, wdata: d};
    @(posedge clock);
    hostReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1;
  endtask
  task automatic writeReg(input logic [4:0] a, input logic [7:0] d);
    busCycle(1'b0, a, {8'h00, d});
  endtask
  // answer is taken in the cycle after the strobe edge
  task automatic readReg(input logic [4:0] a, output logic [15:0] d,
                         output logic v);
    busCycle(1'b1, a, 16'h0000);
    d = readData;
    v = readValid;
  endtask
  // page is chosen first, or the banked offset hits the wrong register
  task automatic pageWrite(input logic [1:0] pg, input logic [4:0] a,
                           input logic [7:0] d);
    writeReg(OFF_CMD, {pg, 6'h21});
    writeReg(a, d);
  endtask
endmodule

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the paged MAC register decoder
// Assumes: one 10 MHz clock, synchronous reset held 12 cycles
// Notes: data port reads return zero, it only raises pulses
`timescale 1ns/1ps
`define CHK(g, e) check((g), (e))
module tb_top
  import mac_regs_pkg::*;
;
  logic clock;
  logic srst;
  host_req_t hostReq;
  core_stat_t coreStat;
  logic [15:0] readData;
  logic readValid;
  logic [7:0] commandOut;
  logic wordWidth;
  logic [47:0] stationAddress;
  logic [63:0] multicastHash;
  logic [7:0] rxWritePage;
  logic softResetPulse;
  logic hostWakePulse;
  logic dataPortWr;
  logic dataPortRd;
  int nMismatch = 0;
  int cmpCount = 0;
  int cycles = 0;
  localparam logic [7:0] TALLY [4] = '{8'h33, 8'h44, 8'h55, 8'h66};
  localparam logic [4:0] RW_OFF [8] = '{OFF_GAP1, OFF_GAP2, OFF_MGMT,
    OFF_BUFCFG, OFF_FGAP, OFF_MAXLO, OFF_FLOW, OFF_MACCFG};

  paged_mac_register_decoder uut (.clock(clock), .srst(srst),
    .hostReq(hostReq), .coreStat(coreStat), .readData(readData),
    .readValid(readValid), .commandOut(commandOut),
    .wordWidth(wordWidth), .stationAddress(stationAddress),
    .multicastHash(multicastHash), .rxWritePage(rxWritePage),
    .softResetPulse(softResetPulse), .hostWakePulse(hostWakePulse),
    .dataPortWr(dataPortWr), .dataPortRd(dataPortRd));
  host_model host (.clock(clock), .hostReq(hostReq),
    .readData(readData), .readValid(readValid));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every register read must come back valid, upper byte zero
  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    logic [15:0] d;
    logic v;
    host.readReg(a, d, v);
    `CHK(v, 1'b1);
    `CHK(d, {8'h00, e});
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // free-running clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard: the tests need under 200 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nMismatch++;
      printVerdict();
    end
  end

  initial begin
    logic [15:0] d;
    logic v;
    srst = 1'b1;
    coreStat = '0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    coreStat <= '{txStatus: 8'h11, collCount: 8'h22, rxStatus: 8'h33,
      alignTally: 8'h44, crcTally: 8'h55, lostTally: 8'h66,
      xferAddrNow: 16'h7788, txEndPage: 8'h99, devStatus: 8'hAA};
    @(posedge clock);
    #1;
    `CHK(commandOut, CMD_RST);
    `CHK(wordWidth, 1'b0);
    rdChk(OFF_CMD, CMD_RST);
    rdChk(5'h03, BNDRY_RST);
    $display("test reset done");
    // page 0: reads and writes reach different registers, except at 01h..03h and 07h
    host.writeReg(5'h04, 8'h5A);
    rdChk(5'h04, 8'h11);
    host.writeReg(5'h05, 8'h5B);
    rdChk(5'h05, 8'h22);
    rdChk(5'h08, 8'h88);
    rdChk(5'h09, 8'h77);
    host.writeReg(5'h0A, 8'h12);
    rdChk(5'h0A, RSVD_READ);
    host.writeReg(5'h0B, 8'h34);
    rdChk(5'h0B, RSVD_READ);
    for (int i = 0; i < 4; i++) begin
      host.writeReg(5'h0C + 5'(i), 8'h01);
      rdChk(5'h0C + 5'(i), TALLY[i]);
    end
    host.writeReg(5'h07, 8'h3F);
    rdChk(5'h07, 8'h3F);
    `CHK(wordWidth, 1'b1);
    $display("test page0 done");
    // page 1: station address, multicast filter, current page
    host.pageWrite(2'b01, 5'h01, 8'hA0);
    `CHK(commandOut, 8'h61);
    for (int i = 1; i < 6; i++)
      host.writeReg(5'h01 + 5'(i), 8'hA0 + 8'(i));
    for (int i = 0; i < 8; i++)
      host.writeReg(5'h08 + 5'(i), 8'hB0 + 8'(i));
    `CHK(stationAddress, 48'hA5A4_A3A2_A1A0);
    `CHK(multicastHash, 64'hB7B6_B5B4_B3B2_B1B0);
    rdChk(5'h03, 8'hA2);
    rdChk(5'h0F, 8'hB7);
    host.writeReg(5'h07, 8'h4D);
    `CHK(rxWritePage, 8'h4D);
    rdChk(5'h07, 8'h4D);
    // page 2 has nothing behind the window
    host.pageWrite(2'b10, 5'h01, 8'hEE);
    rdChk(5'h01, 8'h00);
    rdChk(OFF_CMD, 8'hA1);
    `CHK(stationAddress, 48'hA5A4_A3A2_A1A0);
    host.writeReg(OFF_CMD, 8'h21);
    rdChk(5'h06, 8'h4D);
    rdChk(5'h01, ZERO8);
    $display("test page1 done");
    // upper offsets written in page 3, read back in page 1
    host.writeReg(OFF_CMD, 8'hE1);
    for (int i = 0; i < 8; i++)
      host.writeReg(RW_OFF[i], 8'hC0 + 8'(i));
    host.writeReg(OFF_MAXHI, 8'hFF);
    host.writeReg(OFF_CMD, 8'h61);
    for (int i = 0; i < 8; i++)
      rdChk(RW_OFF[i], 8'hC0 + 8'(i));
    rdChk(OFF_MAXHI, 8'h0F);
    host.writeReg(OFF_MAXHI, 8'h35);
    rdChk(OFF_MAXHI, 8'h05);
    host.writeReg(OFF_DEVSTAT, 8'h3C);
    rdChk(OFF_DEVSTAT, 8'hAA);
    host.writeReg(OFF_VLANLO, 8'h3D);
    rdChk(OFF_VLANLO, 8'h99);
    host.writeReg(OFF_VLANHI, 8'h3E);
    rdChk(OFF_VLANHI, RSVD_READ);
    host.writeReg(OFF_BYTEORD, 8'h01);
    rdChk(OFF_BYTEORD, RSVD_READ);
    host.readReg(OFF_RSTWAKE, d, v);
    `CHK({v, softResetPulse, hostWakePulse}, 3'b110);
    host.writeReg(OFF_RSTWAKE, 8'h01);
    `CHK({softResetPulse, hostWakePulse}, 2'b01);
    host.writeReg(OFF_DATA_LO, 8'h5C);
    `CHK({dataPortWr, dataPortRd, hostWakePulse}, 3'b100);
    rdChk(OFF_DATA_HI, 8'h00);
    `CHK({dataPortWr, dataPortRd}, 2'b01);
    $display("test upper done");
    // mid-run reset: page and boundary return, written bytes clear
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    `CHK({commandOut, wordWidth}, {CMD_RST, 1'b0});
    `CHK(stationAddress, 48'h0);
    rdChk(5'h03, BNDRY_RST);
    $display("test reset again done");
    printVerdict();
  end
endmodule
